//--- malu_pkg.sv
// malu_pkg: shared types and constants for the alu datapath
`default_nettype none
package malu_pkg;
  localparam int DATA_W = 8;
  localparam int REG_CNT = 16;
  localparam int IDX_W = 4;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic FLAG_RESET = 1'b0;
  // two-cycle instruction: issue cycle plus write-back cycle
  localparam int OP_CYCLES = 2;

  typedef enum logic [4:0] {
    MALU_LOAD, MALU_AND, MALU_OR, MALU_XOR,
    MALU_ADD, MALU_ADD_WITH_CARRY_IN, MALU_SUB, MALU_SUBTRACT_WITH_BORROW_IN,
    MALU_SHIFT_RIGHT_ZERO_FILL, MALU_SHIFT_RIGHT_ONE_FILL,
    MALU_SHIFT_RIGHT_SIGN_EXTEND, MALU_SHIFT_RIGHT_CARRY_IN,
    MALU_ROTATE_RIGHT,
    MALU_SHIFT_LEFT_ZERO_FILL, MALU_SHIFT_LEFT_ONE_FILL,
    MALU_SHIFT_LEFT_LSB_EXTEND, MALU_SHIFT_LEFT_CARRY_IN,
    MALU_ROTATE_LEFT
  } malu_op_t;

  typedef struct packed {
    malu_op_t op;
    logic [3:0] first_operand_register;
    logic [3:0] second_operand_register;
    logic use_constant;
    logic [7:0] constant;
  } malu_cmd_t;

  typedef struct packed {
    logic zero;
    logic carry;
  } malu_flags_t;
endpackage : malu_pkg
`default_nettype wire

//--- malu_shift.sv
// malu_shift: one-bit shift and rotate unit
`default_nettype none
module malu_shift (
  input wire logic [7:0] value,
  input wire logic left,
  input wire logic [1:0] fill_sel,
  input wire logic carry_in,
  output logic [7:0] result,
  output logic carry_out
);
  logic fill;
  always_comb begin
    // fill: 0 zero, 1 one, 2 end bit kept, 3 old carry
    unique case (fill_sel)
      2'h0: fill = 1'b0;
      2'h1: fill = 1'b1;
      2'h2: fill = left ? value[0] : value[7];
      default: fill = carry_in;
    endcase
    if (left) begin
      result = {value[6:0], fill};
      carry_out = value[7];
    end else begin
      result = {fill, value[7:1]};
      carry_out = value[0];
    end
  end
endmodule : malu_shift
`default_nettype wire

//--- malu_core.sv
// malu_core: register file, alu and flags of the small controller
// What this block does
// - load copies constant or register, flags kept
// - first register is destination; second register/constant
// - self-load is a two-cycle no-operation
// - loading zero clears register, flags kept
// - and writes bitwise and, updates flags
// - or writes bitwise or, updates flags
// - xor writes bitwise xor, updates flags
// - logical ops set zero on zero result
// - add ignores carry input, updates flags
// - add with carry adds carry flag too
// - sub ignores carry input, stores difference
// - sub sets carry on underflow, modulo result
// - subtract with borrow also subtracts carry
// - right shifts modify one register, update flags
// - left shifts modify one register, update flags
// - sixteen eight-bit registers, four-bit index
// - zero and carry flags exported for branches
`default_nettype none
module malu_core #(
  parameter int REGS = malu_pkg::REG_CNT
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CMD_VALID,
  input wire malu_pkg::malu_cmd_t CMD,
  output logic CMD_READY,
  output logic DONE,
  output malu_pkg::malu_flags_t FLAGS,
  output logic [7:0] RESULT
);
  initial begin
    if (REGS != malu_pkg::REG_CNT) $error("malu_core: REGS must be 16");
  end

  typedef enum logic {MALU_IDLE, MALU_WRITE} malu_state_t;

  logic [7:0] regs_q [REGS];
  logic [7:0] regs_d [REGS];
  malu_state_t state_q, state_d;
  malu_pkg::malu_cmd_t cmd_q, cmd_d;
  malu_pkg::malu_flags_t flags_q, flags_d;
  logic [7:0] result_q, result_d;
  logic [7:0] op_a, op_b, alu_res;
  logic [8:0] wide;
  logic alu_carry, flags_upd, sh_carry;
  logic [7:0] sh_res;
  logic sh_left;
  logic [1:0] sh_fill;

  // operand fetch: any of the sixteen registers by index
  assign op_a = regs_q[cmd_q.first_operand_register];
  assign op_b = cmd_q.use_constant ? cmd_q.constant
              : regs_q[cmd_q.second_operand_register];

  always_comb begin
    unique case (cmd_q.op)
      malu_pkg::MALU_SHIFT_LEFT_ZERO_FILL,
      malu_pkg::MALU_SHIFT_LEFT_ONE_FILL,
      malu_pkg::MALU_SHIFT_LEFT_LSB_EXTEND,
      malu_pkg::MALU_SHIFT_LEFT_CARRY_IN,
      malu_pkg::MALU_ROTATE_LEFT: sh_left = 1'b1;
      default: sh_left = 1'b0;
    endcase
    unique case (cmd_q.op)
      malu_pkg::MALU_SHIFT_RIGHT_ONE_FILL,
      malu_pkg::MALU_SHIFT_LEFT_ONE_FILL: sh_fill = 2'h1;
      malu_pkg::MALU_SHIFT_RIGHT_SIGN_EXTEND,
      malu_pkg::MALU_SHIFT_LEFT_LSB_EXTEND: sh_fill = 2'h2;
      malu_pkg::MALU_SHIFT_RIGHT_CARRY_IN,
      malu_pkg::MALU_SHIFT_LEFT_CARRY_IN: sh_fill = 2'h3;
      default: sh_fill = 2'h0;
    endcase
  end

  // rotates feed the ejected end bit back in through the carry-in slot
  logic [7:0] sh_in;
  logic [1:0] sh_sel;
  always_comb begin
    sh_in = op_a;
    sh_sel = sh_fill;
    if (cmd_q.op == malu_pkg::MALU_ROTATE_RIGHT) begin
      sh_sel = 2'h3;
    end else if (cmd_q.op == malu_pkg::MALU_ROTATE_LEFT) begin
      sh_sel = 2'h3;
    end
  end
  logic rot_bit;
  assign rot_bit = sh_left ? op_a[7] : op_a[0];
  logic sh_cin;
  assign sh_cin = (cmd_q.op == malu_pkg::MALU_ROTATE_RIGHT ||
                   cmd_q.op == malu_pkg::MALU_ROTATE_LEFT)
                  ? rot_bit : flags_q.carry;

  malu_shift u_shift (
    .value(sh_in),
    .left(sh_left),
    .fill_sel(sh_sel),
    .carry_in(sh_cin),
    .result(sh_res),
    .carry_out(sh_carry)
  );

  always_comb begin
    wide = 9'h000;
    alu_res = op_a;
    alu_carry = flags_q.carry;
    flags_upd = 1'b1;
    unique case (cmd_q.op)
      malu_pkg::MALU_LOAD: begin
        alu_res = op_b;
        flags_upd = 1'b0;
      end
      malu_pkg::MALU_AND: begin
        alu_res = op_a & op_b;
        alu_carry = 1'b0;
      end
      malu_pkg::MALU_OR: begin
        alu_res = op_a | op_b;
        alu_carry = 1'b0;
      end
      malu_pkg::MALU_XOR: begin
        alu_res = op_a ^ op_b;
        alu_carry = 1'b0;
      end
      malu_pkg::MALU_ADD: begin
        wide = {1'b0, op_a} + {1'b0, op_b};
        alu_res = wide[7:0];
        alu_carry = wide[8];
      end
      malu_pkg::MALU_ADD_WITH_CARRY_IN: begin
        wide = {1'b0, op_a} + {1'b0, op_b}
             + {8'h00, flags_q.carry};
        alu_res = wide[7:0];
        alu_carry = wide[8];
      end
      malu_pkg::MALU_SUB: begin
        // borrow appears as bit 8 of the nine-bit difference
        wide = {1'b0, op_a} - {1'b0, op_b};
        alu_res = wide[7:0];
        alu_carry = wide[8];
      end
      malu_pkg::MALU_SUBTRACT_WITH_BORROW_IN: begin
        wide = {1'b0, op_a} - {1'b0, op_b}
             - {8'h00, flags_q.carry};
        alu_res = wide[7:0];
        alu_carry = wide[8];
      end
      default: begin
        alu_res = sh_res;
        alu_carry = sh_carry;
      end
    endcase
  end

  // issue cycle latches the command, second cycle writes back
  always_comb begin
    state_d = state_q;
    cmd_d = cmd_q;
    flags_d = flags_q;
    result_d = result_q;
    for (int i = 0; i < REGS; i++) begin
      regs_d[i] = regs_q[i];
    end
    unique case (state_q)
      MALU_IDLE: begin
        if (CMD_VALID) begin
          cmd_d = CMD;
          state_d = MALU_WRITE;
        end
      end
      MALU_WRITE: begin
        // self-load rewrites the same value: a two-cycle no-op
        regs_d[cmd_q.first_operand_register] = alu_res;
        result_d = alu_res;
        if (flags_upd) begin
          flags_d.zero = (alu_res == 8'h00);
          flags_d.carry = alu_carry;
        end
        state_d = MALU_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      state_q <= MALU_IDLE;
      cmd_q <= '0;
      flags_q <= '{zero: malu_pkg::FLAG_RESET, carry: malu_pkg::FLAG_RESET};
      result_q <= malu_pkg::REG_RESET;
      for (int i = 0; i < REGS; i++) begin
        regs_q[i] <= malu_pkg::REG_RESET;
      end
    end else begin
      state_q <= state_d;
      cmd_q <= cmd_d;
      flags_q <= flags_d;
      result_q <= result_d;
      for (int i = 0; i < REGS; i++) begin
        regs_q[i] <= regs_d[i];
      end
    end
  end

  logic done_q;
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      done_q <= 1'b0;
    end else begin
      done_q <= (state_q == MALU_WRITE);
    end
  end

  assign CMD_READY = (state_q == MALU_IDLE);
  assign DONE = done_q;
  assign FLAGS = flags_q;
  assign RESULT = result_q;

  sequence s_issue;
    CMD_VALID && CMD_READY;
  endsequence

  a_load_flags: assert property (
    @(posedge CLK) disable iff (!RST_N)
    s_issue and (CMD.op == malu_pkg::MALU_LOAD) |=> ##1 $stable(FLAGS))
    else $error("load changed flags");
  a_two_cycle: assert property (
    @(posedge CLK) disable iff (!RST_N)
    s_issue |-> ##2 DONE)
    else $error("op did not finish in two cycles");
  a_ready_low: assert property (
    @(posedge CLK) disable iff (!RST_N)
    s_issue |=> !CMD_READY ##1 CMD_READY)
    else $error("ready timing wrong");
  a_zero_flag: assert property (
    @(posedge CLK) disable iff (!RST_N)
    DONE && cmd_q.op != malu_pkg::MALU_LOAD
      |-> FLAGS.zero == (RESULT == 8'h00))
    else $error("zero flag mismatch");
  a_logic_carry: assert property (
    @(posedge CLK) disable iff (!RST_N)
    DONE && (cmd_q.op == malu_pkg::MALU_AND || cmd_q.op == malu_pkg::MALU_OR
      || cmd_q.op == malu_pkg::MALU_XOR) |-> !FLAGS.carry)
    else $error("logic op left carry set");
  // operands are taken one edge back: write-back has replaced them since
  a_sub_borrow: assert property (
    @(posedge CLK) disable iff (!RST_N)
    state_q == MALU_WRITE && cmd_q.op == malu_pkg::MALU_SUB
      |=> FLAGS.carry == ($past(op_b) > $past(op_a)))
    else $error("sub borrow wrong");
  a_add_result: assert property (
    @(posedge CLK) disable iff (!RST_N)
    state_q == MALU_WRITE && cmd_q.op == malu_pkg::MALU_ADD
      |=> RESULT == 8'($past(op_a) + $past(op_b)))
    else $error("add result wrong");
  a_dest_write: assert property (
    @(posedge CLK) disable iff (!RST_N)
    state_q == MALU_WRITE
      |=> regs_q[$past(cmd_q.first_operand_register)] == RESULT)
    else $error("destination not written");
endmodule : malu_core
`default_nettype wire

//--- malu_seq_model.sv
// malu_seq_model: command driver and flag-testing sequencer model
`default_nettype none
module malu_seq_model (
  input wire logic CLK,
  input wire logic CMD_READY,
  input wire logic DONE,
  input wire malu_pkg::malu_flags_t FLAGS,
  output var logic CMD_VALID,
  output var malu_pkg::malu_cmd_t CMD,
  output logic take_z,
  output logic take_c
);
  timeunit 1ns;
  timeprecision 100ps;
  // branch decisions test the registered flags only
  assign take_z = FLAGS.zero;
  assign take_c = FLAGS.carry;
  initial begin
    CMD_VALID = 1'b0;
    CMD = '0;
  end
  // issue one op; spam keeps offering a stray load while busy
  task automatic run(input malu_pkg::malu_cmd_t c, input logic spam,
                     output int lat);
    @(negedge CLK);
    CMD_VALID = 1'b1;
    CMD = c; // register or constant second operand
    while (!CMD_READY) @(negedge CLK);
    @(negedge CLK);
    lat = 1;
    CMD_VALID = spam;
    // released lines show inverse, or the stray load if spam, never stale data
    if (spam) CMD = malu_pkg::malu_cmd_t'({5'h00, 4'h3, 4'h0, 1'h1, 8'h77});
    else CMD = malu_pkg::malu_cmd_t'(~c);
    while (!DONE && lat < 8) begin
      @(negedge CLK);
      lat++;
      CMD_VALID = 1'b0;
    end
  endtask : run
endmodule : malu_seq_model
`default_nettype wire

//--- malu_core_tb_top.sv
// malu_core_tb_top: table-driven bench for the alu datapath
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin mismatches++; \
  $display("Error at %0t: got %h want %h", $time, a, b); end end
module malu_core_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic CLK, RST_N, CMD_VALID, CMD_READY, DONE, take_z, take_c;
  malu_pkg::malu_cmd_t CMD;
  malu_pkg::malu_flags_t FLAGS;
  logic [7:0] RESULT;
  int mismatches = 0, checks = 0, cyc = 0, lat;
  // op_x_y_useconst_const_result_zc, run in order; carry chains on
  logic [43:0] rows [24] = '{
    44'h00_1_0_1_0F_0F_00, 44'h00_2_0_1_33_33_00,
    44'h01_1_2_0_00_03_00, 44'h02_2_0_1_0F_3F_00,
    44'h03_2_0_1_3F_00_10, 44'h00_5_0_1_27_27_10,
    44'h06_5_0_1_35_F2_01, 44'h04_5_0_1_0E_00_11,
    44'h07_5_0_1_00_FF_01, 44'h05_5_0_1_00_00_11,
    44'h06_5_0_1_00_00_10, 44'h06_5_0_1_01_FF_01,
    44'h01_1_0_1_FF_03_00, 44'h04_5_1_0_00_02_01,
    44'h00_6_0_1_81_81_01, 44'h0C_6_0_0_00_C0_01,
    44'h0B_6_0_0_00_E0_00, 44'h08_6_0_0_00_70_00,
    44'h09_6_0_0_00_B8_00, 44'h0A_6_0_0_00_DC_00,
    44'h11_6_0_0_00_B9_01, 44'h10_6_0_0_00_73_01,
    44'h0D_6_0_0_00_E6_00, 44'h0E_6_0_0_00_CD_01
  };
  logic [43:0] tail [4] = '{
    44'h0F_6_0_0_00_9B_01, 44'h00_7_0_1_01_01_01,
    44'h08_7_0_0_00_00_11, 44'h04_F_6_0_00_9B_00
  };
  malu_core u_malu_core (.CLK(CLK), .RST_N(RST_N), .CMD_VALID(CMD_VALID),
    .CMD(CMD), .CMD_READY(CMD_READY), .DONE(DONE), .FLAGS(FLAGS),
    .RESULT(RESULT));
  malu_seq_model u_malu_seq_model (.CLK(CLK), .CMD_READY(CMD_READY),
    .DONE(DONE), .FLAGS(FLAGS), .CMD_VALID(CMD_VALID), .CMD(CMD),
    .take_z(take_z), .take_c(take_c));
  initial begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 1000) begin
      mismatches++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  task automatic step(input logic [21:0] c, input logic spam,
                      input logic [7:0] res, input logic z, input logic cy);
    u_malu_seq_model.run(malu_pkg::malu_cmd_t'(c), spam, lat);
    `CHK(lat, malu_pkg::OP_CYCLES)
    `CHK(RESULT, res)
    `CHK(FLAGS.zero, z)
    `CHK(FLAGS.carry, cy)
    `CHK({take_z, take_c}, {z, cy})
  endtask : step
  task automatic row(input logic [43:0] r);
    step({r[40:36], r[35:28], r[24:16]}, 1'h0, r[15:8], r[4], r[0]);
  endtask : row
  initial begin
    RST_N = 1'b0;
    repeat (2) @(negedge CLK);
    RST_N = 1'b1;
    foreach (rows[i]) row(rows[i]);
    foreach (tail[i]) row(tail[i]);
    $display("table done");
    // self-load changes nothing and still takes two cycles
    step({5'h00, 4'h6, 4'h6, 1'h0, 8'h00}, 1'h0, 8'h9B,
         1'h0, 1'h0);
    // clear keeps a clear zero flag; stray offer while busy
    step({5'h00, 4'h5, 4'h0, 1'h1, 8'h00}, 1'h1, 8'h00,
         1'h0, 1'h0);
    step({5'h00, 4'h3, 4'h3, 1'h0, 8'h00}, 1'h0, 8'h00,
         1'h0, 1'h0);
    $display("hand tests done");
    @(negedge CLK);
    RST_N = 1'b0;
    repeat (2) @(negedge CLK);
    RST_N = 1'b1;
    `CHK(FLAGS, 2'h0)
    `CHK({CMD_READY, DONE}, 2'h2)
    step({5'h00, 4'h6, 4'h6, 1'h0, 8'h00}, 1'h0, 8'h00,
         1'h0, 1'h0);
    $display("reset test done");
    give_verdict();
  end
endmodule : malu_core_tb_top
`default_nettype wire
